// ===== rtl/usm_top.sv
// usm_top: two serial channels with mode select, transmit control and pin direction
// assumes strobes from a same-clock master; serial pins arrive asynchronous and are synchronised here
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps

module usm_channel (
  input wire logic clk,
  input wire logic rst_n,
  input usm_pkg::usm_bus_type bus,
  input wire logic sel,
  input usm_pkg::usm_pin_in_type pin_in,
  output usm_pkg::usm_pin_out_type pin_out,
  output logic [7:0] rd_val,
  output logic irq
);
  import usm_pkg::*;

  typedef struct packed {
    logic [7:0] txctl;
    logic [7:0] rcctl;
    logic [7:0] baud;
    logic [7:0] bcnt;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic [7:0] rxbuf;
    logic rx_ninth;
    logic rxbuf_full;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic d_meta;
    logic d_sync;
    logic d_prev;
    logic c_meta;
    logic c_sync;
    logic c_prev;
    usm_tx_phase_type tx_phase;
    logic [3:0] tx_nbits;
    logic [8:0] tx_shift;
    logic tx_sub;
    logic tx_line;
    usm_rx_phase_type rx_phase;
    logic [3:0] rx_nbits;
    logic [8:0] rx_shift;
    logic rx_sub;
    logic sclk;
    usm_pin_out_type pins;
  } usm_chan_state_type;

  usm_chan_state_type s_reg;
  usm_chan_state_type s_next;

  // ==========================================================================
  // register read view
  always_comb begin
    unique case (bus.addr[4:0])
      OFF_TXCTL: rd_val = s_reg.txctl;
      OFF_RCCTL: rd_val = s_reg.rcctl;
      OFF_BAUD: rd_val = s_reg.baud;
      OFF_RXBUF: rd_val = s_reg.rxbuf;
      OFF_STAT: rd_val = {5'h00, s_reg.status};
      OFF_MASK: rd_val = {5'h00, s_reg.mask};
      default: rd_val = 8'h00;
    endcase
  end

  assign irq = |(s_reg.status & s_reg.mask);
  assign pin_out = s_reg.pins;

  // ==========================================================================
  // next state
  always_comb begin
    logic wr_hit;
    logic tick;
    logic serial_port_enable;
    logic sync_m;
    logic master;
    logic rx_req;
    logic tx_ok;
    logic tx_adv;
    logic rx_adv;
    logic lead;
    logic trail;
    logic got_rx;
    logic [8:0] word;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    s_next = s_reg;
    wr_hit = bus.wr && sel;
    got_rx = 1'b0;
    word = 9'h000;
    ev = '0;
    clr = '0;
    tick = (s_reg.bcnt == 8'h00);
    s_next.bcnt = tick ? s_reg.baud : s_reg.bcnt - 8'h01;
    // pin synchronisers: the second stage gives the level, the third stage the previous level for edge detection
    s_next.d_meta = pin_in.data_in;
    s_next.d_sync = s_reg.d_meta;
    s_next.d_prev = s_reg.d_sync;
    s_next.c_meta = pin_in.clk_in;
    s_next.c_sync = s_reg.c_meta;
    s_next.c_prev = s_reg.c_sync;
    serial_port_enable = s_reg.rcctl[RC_SERIAL_PORT_ENABLE];
    sync_m = s_reg.txctl[TX_SYNC];
    master = s_reg.txctl[TX_CLOCK_SOURCE_SELECT];
    // receive in a slave ignores single receive
    rx_req = serial_port_enable && sync_m && (s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE] || (master && s_reg.rcctl[RC_SINGLE_RECEIVE_ENABLE]));
    tx_ok = serial_port_enable && s_reg.txctl[TX_EN] && !(sync_m && (s_reg.rcctl[RC_SINGLE_RECEIVE_ENABLE] || s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE]));
    tx_adv = tick && !s_reg.tx_sub;
    rx_adv = tick && !s_reg.rx_sub;
    s_next.tx_sub = tick ? ~s_reg.tx_sub : s_reg.tx_sub;
    s_next.rx_sub = tick ? ~s_reg.rx_sub : s_reg.rx_sub;
    if (master) begin
      trail = tick && !s_reg.sclk;
      lead = tick && s_reg.sclk;
    end else begin
      trail = s_reg.c_sync && !s_reg.c_prev;
      lead = !s_reg.c_sync && s_reg.c_prev;
    end

    // register writes
    if (wr_hit) begin
      unique case (bus.addr[4:0])
        OFF_TXCTL: s_next.txctl = (bus.wdata & TXCTL_WMASK) | (s_reg.txctl & ~TXCTL_WMASK);
        OFF_RCCTL: begin
          s_next.rcctl = (bus.wdata & RCCTL_WMASK) | (s_reg.rcctl & ~RCCTL_WMASK);
          if (!bus.wdata[RC_CONTINUOUS_RECEIVE_ENABLE]) begin
            s_next.rcctl[RC_OVR] = 1'b0;
          end
        end
        OFF_BAUD: s_next.baud = bus.wdata;
        OFF_TXBUF: begin
          s_next.txbuf = bus.wdata;
          s_next.txbuf_full = 1'b1;
        end
        OFF_STAT: clr = bus.wdata[EV_W-1:0];
        OFF_MASK: s_next.mask = bus.wdata[EV_W-1:0];
        default: ;
      endcase
    end
    if (bus.rd && sel && bus.addr[4:0] == OFF_RXBUF) begin
      s_next.rxbuf_full = 1'b0;
    end

    // ========================================================================
    // transmitter
    if (!serial_port_enable || !s_reg.txctl[TX_EN]) begin
      s_next.tx_phase = TXP_IDLE;
      s_next.tx_line = 1'b1;
      s_next.txctl[TX_EMPTY] = 1'b1;
    end else begin
      unique case (s_reg.tx_phase)
        TXP_IDLE: begin
          // half duplex: never start while the receiver owns the sync link
          if (tx_ok && s_reg.txbuf_full && !(sync_m && s_reg.rx_phase != RXP_IDLE)) begin
            // a buffer write in the load cycle keeps the buffer full, so that word is not lost
            s_next.txbuf_full = wr_hit && (bus.addr[4:0] == OFF_TXBUF);
            s_next.txctl[TX_EMPTY] = 1'b0;
            ev[EV_TX] = 1'b1;
            s_next.tx_nbits = s_reg.txctl[TX_NINE] ? BITS_9 : BITS_8;
            if (!sync_m) begin
              s_next.tx_shift = {s_reg.txctl[TX_NINTH], s_reg.txbuf};
              s_next.tx_line = 1'b0;
              s_next.tx_sub = 1'b1;
              s_next.tx_phase = TXP_ASYNC;
            end else begin
              s_next.tx_line = s_reg.txbuf[0];
              s_next.tx_shift = {1'b0, s_reg.txctl[TX_NINTH], s_reg.txbuf[7:1]};
              s_next.tx_nbits = s_next.tx_nbits - 4'h1;
              s_next.tx_phase = TXP_SYNC;
            end
          end
        end
        TXP_ASYNC: begin
          if (tx_adv) begin
            if (s_reg.tx_nbits != 4'h0) begin
              s_next.tx_line = s_reg.tx_shift[0];
              s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
              s_next.tx_nbits = s_reg.tx_nbits - 4'h1;
            end else begin
              s_next.tx_line = 1'b1;
              s_next.tx_phase = TXP_STOP;
            end
          end
        end
        TXP_STOP: begin
          if (tx_adv) begin
            s_next.tx_phase = TXP_IDLE;
            s_next.txctl[TX_EMPTY] = 1'b1;
          end
        end
        TXP_SYNC: begin
          if (lead) begin
            if (s_reg.tx_nbits != 4'h0) begin
              s_next.tx_line = s_reg.tx_shift[0];
              s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
              s_next.tx_nbits = s_reg.tx_nbits - 4'h1;
            end else begin
              s_next.tx_phase = TXP_IDLE;
              s_next.txctl[TX_EMPTY] = 1'b1;
            end
          end
        end
      endcase
    end

    // ========================================================================
    // receiver, independent of the transmitter for full duplex in async mode; a sync receive starts only while the transmitter is idle
    if (!serial_port_enable) begin
      s_next.rx_phase = RXP_IDLE;
    end else begin
      unique case (s_reg.rx_phase)
        RXP_IDLE: begin
          s_next.rx_nbits = s_reg.rcctl[RC_RX9] ? BITS_9 : BITS_8;
          if (!sync_m && s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE] && !s_reg.d_sync && s_reg.d_prev) begin
            s_next.rx_sub = 1'b0;
            s_next.rx_phase = RXP_START;
          end else if (rx_req && s_reg.tx_phase == TXP_IDLE) begin
            s_next.rx_phase = RXP_SYNC;
          end
        end
        RXP_START: begin
          // a start bit gone high at mid-bit was a glitch
          if (rx_adv) begin
            s_next.rx_phase = s_reg.d_sync ? RXP_IDLE : RXP_ASYNC;
          end
        end
        RXP_ASYNC: begin
          if (rx_adv) begin
            if (s_reg.rx_nbits != 4'h0) begin
              s_next.rx_shift = {s_reg.d_sync, s_reg.rx_shift[8:1]};
              s_next.rx_nbits = s_reg.rx_nbits - 4'h1;
            end else begin
              got_rx = 1'b1;
              word = s_reg.rx_shift;
              s_next.rx_phase = RXP_IDLE;
            end
          end
        end
        RXP_SYNC: begin
          if (!rx_req) begin
            s_next.rx_phase = RXP_IDLE;
          end else if (trail) begin
            s_next.rx_shift = {s_reg.d_sync, s_reg.rx_shift[8:1]};
            s_next.rx_nbits = s_reg.rx_nbits - 4'h1;
            if (s_reg.rx_nbits == 4'h1) begin
              got_rx = 1'b1;
              word = s_next.rx_shift;
              s_next.rx_nbits = s_reg.rcctl[RC_RX9] ? BITS_9 : BITS_8;
              if (!s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE]) begin
                s_next.rcctl[RC_SINGLE_RECEIVE_ENABLE] = 1'b0;
                s_next.rx_phase = RXP_IDLE;
              end
            end
          end
        end
      endcase
    end
    if (got_rx) begin
      if (!s_reg.rcctl[RC_RX9]) begin
        word = {1'b0, word[8:1]};
      end
      if (s_next.rxbuf_full) begin
        // the unread word is kept, the new one is lost
        s_next.rcctl[RC_OVR] = 1'b1;
        ev[EV_OVR] = 1'b1;
      end else begin
        s_next.rxbuf = word[7:0];
        s_next.rx_ninth = word[8];
        s_next.rcctl[RC_NINTH] = word[8];
        s_next.rxbuf_full = 1'b1;
        ev[EV_RX] = 1'b1;
      end
    end

    // ========================================================================
    // shift clock and pin drive
    if (master && (s_next.tx_phase == TXP_SYNC || s_next.rx_phase == RXP_SYNC)) begin
      s_next.sclk = tick ? ~s_reg.sclk : s_reg.sclk;
    end else begin
      s_next.sclk = 1'b0;
    end
    // set wins over a write-one clear in the same cycle
    s_next.status = (s_reg.status & ~clr) | ev;
    s_next.pins.clk_oe_n = !(s_next.rcctl[RC_SERIAL_PORT_ENABLE] && (!s_next.txctl[TX_SYNC] || s_next.txctl[TX_CLOCK_SOURCE_SELECT]));
    s_next.pins.clk_out = s_next.txctl[TX_SYNC] ? s_next.sclk : s_next.tx_line;
    s_next.pins.data_oe_n = !(s_next.rcctl[RC_SERIAL_PORT_ENABLE] && s_next.txctl[TX_SYNC] && s_next.txctl[TX_EN]
                              && !s_next.rcctl[RC_SINGLE_RECEIVE_ENABLE] && !s_next.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE]);
    s_next.pins.data_out = s_next.tx_line;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.txctl <= TXCTL_RST;
      s_reg.rcctl <= RCCTL_RST;
      s_reg.baud <= BAUD_RST;
      s_reg.tx_line <= 1'b1;
      s_reg.pins.data_out <= 1'b1;
      s_reg.pins.clk_out <= 1'b1;
      s_reg.pins.data_oe_n <= 1'b1;
      s_reg.pins.clk_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // checks
  chk_async_pin_dir: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.rcctl[RC_SERIAL_PORT_ENABLE] && !s_reg.txctl[TX_SYNC] |-> s_reg.pins.data_oe_n && !s_reg.pins.clk_oe_n)
    else $error("async mode pin direction wrong");
  chk_sync_clk_dir: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.rcctl[RC_SERIAL_PORT_ENABLE] && s_reg.txctl[TX_SYNC] |-> s_reg.pins.clk_oe_n == !s_reg.txctl[TX_CLOCK_SOURCE_SELECT])
    else $error("sync clock pin direction does not follow source select");
  chk_mode_bit_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && sel && bus.addr[4:0] == OFF_TXCTL |=> s_reg.txctl[TX_SYNC] == $past(bus.wdata[TX_SYNC]))
    else $error("mode select bit not stored");
  chk_transmitter_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !s_reg.txctl[TX_EN] |=> s_reg.tx_phase == TXP_IDLE)
    else $error("transmitter ran while disabled");
  chk_sync_rx_wins: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.txctl[TX_SYNC] && (s_reg.rcctl[RC_SINGLE_RECEIVE_ENABLE] || s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE]) && s_reg.tx_phase == TXP_IDLE
    |=> s_reg.tx_phase == TXP_IDLE)
    else $error("sync transmit started while receive enabled");
  chk_empty_busy: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.tx_phase != TXP_IDLE |-> !s_reg.txctl[TX_EMPTY])
    else $error("empty flag set while shifting");
  chk_empty_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> s_reg.txctl[TX_EMPTY] && s_reg.txctl[3:2] == 2'b00)
    else $error("empty flag not one after reset");
  chk_nine_bit_len: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.tx_phase == TXP_IDLE ##1 s_reg.tx_phase == TXP_ASYNC
    |-> s_reg.tx_nbits == ($past(s_reg.txctl[TX_NINE]) ? BITS_9 : BITS_8))
    else $error("frame length does not follow nine-bit select");
  chk_cont_rx: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.rx_phase == RXP_SYNC && s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE] ##1 s_reg.rcctl[RC_CONTINUOUS_RECEIVE_ENABLE] && s_reg.rcctl[RC_SERIAL_PORT_ENABLE]
    && s_reg.txctl[TX_SYNC] |-> s_reg.rx_phase == RXP_SYNC)
    else $error("continuous receive stopped while enabled");
  chk_pin_release: assert property (@(posedge clk) disable iff (!rst_n)
    !s_reg.rcctl[RC_SERIAL_PORT_ENABLE] |-> s_reg.pins.data_oe_n && s_reg.pins.clk_oe_n)
    else $error("pins driven while port disabled");

  cov_async_done: cover property (@(posedge clk) disable iff (!rst_n)
    s_reg.tx_phase == TXP_STOP ##1 s_reg.tx_phase == TXP_IDLE);
  cov_sync_tx: cover property (@(posedge clk) disable iff (!rst_n) s_reg.tx_phase == TXP_SYNC);
  cov_rx_word: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_reg.rxbuf_full));
  cov_overrun: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_reg.rcctl[RC_OVR]));
endmodule // usm_channel

module usm_top (
  input wire logic clk,
  input wire logic rst_n,
  input usm_pkg::usm_bus_type bus,
  input usm_pkg::usm_pin_in_type [usm_pkg::NUM_CHANNELS-1:0] pin_in,
  output usm_pkg::usm_pin_out_type [usm_pkg::NUM_CHANNELS-1:0] pin_out,
  output logic [7:0] rdata,
  output logic irq
);
  import usm_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic irq;
  } usm_top_state_type;

  usm_top_state_type t_reg;
  usm_top_state_type t_next;
  logic [NUM_CHANNELS-1:0][7:0] ch_rd;
  logic [NUM_CHANNELS-1:0] ch_irq;

  // ==========================================================================
  // channels
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
    usm_channel u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .bus(bus),
      .sel(bus.addr[CHAN_SEL_BIT] == 1'(g)),
      .pin_in(pin_in[g]),
      .pin_out(pin_out[g]),
      .rd_val(ch_rd[g]),
      .irq(ch_irq[g])
    );
  end

  // read data stand only in the cycle after the strobe
  always_comb begin
    t_next.rdata = bus.rd ? ch_rd[bus.addr[CHAN_SEL_BIT]] : 8'h00;
    t_next.irq = |ch_irq;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign rdata = t_reg.rdata;
  assign irq = t_reg.irq;

  chk_rdata_window: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside the answer cycle");
  cov_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule // usm_top

// ===== rtl/usm_pkg.sv
// usm_pkg: constants, states and carriers of the dual serial mode/transmit block
// assumes a 100 MHz core clock and one 8-bit register port shared by both channels
package usm_pkg;

  // ==========================================================================
  // register map: addr[5] picks the channel, addr[4:0] the register
  localparam int NUM_CHANNELS = 2;
  localparam int ADDR_W = 6;
  localparam int CHAN_SEL_BIT = 5;
  localparam logic [4:0] OFF_RCCTL = 5'h13;
  localparam logic [4:0] OFF_RXBUF = 5'h14;
  localparam logic [4:0] OFF_TXCTL = 5'h15;
  localparam logic [4:0] OFF_TXBUF = 5'h16;
  localparam logic [4:0] OFF_BAUD = 5'h17;
  localparam logic [4:0] OFF_STAT = 5'h18;
  localparam logic [4:0] OFF_MASK = 5'h19;

  // ==========================================================================
  // transmit_control_register fields
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;
  localparam logic [7:0] TXCTL_WMASK = 8'hF1;
  localparam logic [7:0] TXCTL_RST = 8'h02;

  // receive_control_register fields
  localparam int RC_SERIAL_PORT_ENABLE = 7;
  localparam int RC_RX9 = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RC_OVR = 1;
  localparam int RC_NINTH = 0;
  localparam logic [7:0] RCCTL_WMASK = 8'hF0;
  localparam logic [7:0] RCCTL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // event status / mask bits
  localparam int EV_W = 3;
  localparam int EV_TX = 0;
  localparam int EV_RX = 1;
  localparam int EV_OVR = 2;

  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  // ==========================================================================
  typedef enum logic [1:0] {TXP_IDLE, TXP_ASYNC, TXP_STOP, TXP_SYNC} usm_tx_phase_type;
  typedef enum logic [1:0] {RXP_IDLE, RXP_START, RXP_ASYNC, RXP_SYNC} usm_rx_phase_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usm_bus_type;

  typedef struct packed {
    logic data_in;
    logic clk_in;
  } usm_pin_in_type;

  typedef struct packed {
    logic data_out;
    logic data_oe_n;
    logic clk_out;
    logic clk_oe_n;
  } usm_pin_out_type;

endpackage

// ===== sim/usm_peer.sv
// usm_peer: external serial peer on one channel's data and clock pins
// assumes the bench resolves each wire from the block's enables and these drives
`timescale 1ns/100ps

module usm_peer (
  input wire logic clk,
  input wire logic d_wire,
  input wire logic c_wire,
  output logic d_drv,
  output logic c_drv
);
  // ==========================================================================
  // released lines: data pulled high, clock pulled low (sync clock idles low)
  initial begin
    d_drv = 1'b1;
    c_drv = 1'b0;
  end

  // ==========================================================================
  // async receive on the transmit wire; bit nb of v is the stop bit
  task automatic recv_async(input int bitc, input int nb, output logic [15:0] v);
    int t;
    v = '0;
    t = 0;
    while (c_wire !== 1'b0 && t < 2000) begin
      @(posedge clk);
      #1;
      t++;
    end
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bitc) @(posedge clk);
      #1 v[i] = c_wire;
    end
  endtask

  // hold the data wire at one level while the block samples it
  task automatic hold_data(input logic b);
    d_drv <= b;
  endtask

  // async send: start, nb data bits lsb first, stop
  task automatic send_async(input int bitc, input int nb, input logic [15:0] w);
    for (int i = 0; i <= nb + 1; i++) begin
      @(posedge clk);
      d_drv <= (i == 0) ? 1'b0 : ((i == nb + 1) ? 1'b1 : w[i - 1]);
      repeat (bitc - 1) @(posedge clk);
    end
  endtask

  // sync receive of one byte on rising clock edges; as slave this end makes the clock
  task automatic sync_recv(input logic master, output logic [7:0] v);
    int t;
    t = 0;
    // slave clock waits for the buffer load, then runs only for this frame
    if (!master) #103;
    for (int i = 0; i < 8; i++) begin
      if (master) begin
        while (c_wire !== 1'b0 && t < 400) begin
          @(posedge clk);
          #1;
          t++;
        end
        while (c_wire !== 1'b1 && t < 400) begin
          @(posedge clk);
          #1;
          t++;
        end
      end else begin
        #40 c_drv = 1'b1;
      end
      v[i] = d_wire;
      if (!master) #40 c_drv = 1'b0;
    end
  endtask
endmodule // usm_peer

// ===== sim/usm_top_tb.sv
// usm_top_tb: self-checking bench for the dual serial mode and transmit block
// assumes usm_pkg, usm_top and the peer model usm_peer; one peer per channel
`timescale 1ns/100ps

module usm_top_tb;
  import usm_pkg::*;
  // ==========================================================================
  // clock, reset, bus, pins
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  usm_bus_type bus = '0;
  usm_pin_in_type [NUM_CHANNELS-1:0] pin_in;
  usm_pin_out_type [NUM_CHANNELS-1:0] pin_out;
  logic [7:0] rdata;
  logic irq;
  logic [1:0] d_drv;
  logic [1:0] c_drv;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h9155AD9D;
  int txm [2];
  localparam logic [15:0] DIR_TAB [6] = '{16'h00B0, 16'h80B0, 16'h8030, 16'h90B0, 16'h9030, 16'h8020};
  localparam logic [1:0] DIR_EXP [6] = '{2'b11, 2'b00, 2'b01, 2'b10, 2'b11, 2'b10};

  always #5 clk = ~clk;

  usm_top i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .pin_in(pin_in), .pin_out(pin_out), .rdata(rdata), .irq(irq));

  for (genvar n = 0; n < NUM_CHANNELS; n++) begin : g_pin
    // a released wire shows the peer's drive or its pull level
    assign pin_in[n].data_in = pin_out[n].data_oe_n ? d_drv[n] : pin_out[n].data_out;
    assign pin_in[n].clk_in = pin_out[n].clk_oe_n ? c_drv[n] : pin_out[n].clk_out;
    usm_peer i_peer (.clk(clk), .d_wire(pin_in[n].data_in), .c_wire(pin_in[n].clk_in), .d_drv(d_drv[n]),
      .c_drv(c_drv[n]));
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // model keeps the writable transmit control bits; the empty flag is added per read
  task automatic wr(input int c, input logic [4:0] off, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= {c[0], off};
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    if (off == OFF_TXCTL) txm[c] = int'(d & TXCTL_WMASK);
  endtask

  task automatic rchk(input int c, input logic [4:0] off, input logic [7:0] exp);
    @(posedge clk);
    bus.addr <= {c[0], off};
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] got;
    logic [7:0] v;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      txm[c] = 0;
      rchk(c, OFF_TXCTL, 8'h02);
      rchk(c, OFF_RCCTL, 8'h00);
      wr(c, OFF_TXCTL, 8'hFF);
      rchk(c, OFF_TXCTL, 8'(txm[c]) | 8'h02);
      wr(c, OFF_TXCTL, 8'h00);
      wr(c, 5'h00, 8'hA5);
      rchk(c, 5'h00, 8'h00);
    end
    // pin direction per mode on channel a; channel b stays released
    foreach (DIR_TAB[i]) begin
      wr(0, OFF_RCCTL, DIR_TAB[i][15:8]);
      wr(0, OFF_TXCTL, DIR_TAB[i][7:0]);
      repeat (3) @(posedge clk);
      got = {12'h000, pin_out[0].data_oe_n, pin_out[0].clk_oe_n, pin_out[1].data_oe_n, pin_out[1].clk_oe_n};
      chk(got, {12'h000, DIR_EXP[i], 2'b11});
    end
    wr(0, OFF_TXCTL, 8'h00);
    // async frames of eight then nine bits; interrupt unmasked then masked
    wr(0, OFF_BAUD, 8'h01);
    wr(0, OFF_RCCTL, 8'h80);
    for (int k = 0; k < 2; k++) begin
      r = xs();
      wr(0, OFF_MASK, (k == 0) ? 8'h01 : 8'h00);
      wr(0, OFF_TXCTL, {1'b0, k[0], 1'b1, 4'h0, r[8]});
      fork
        g_pin[0].i_peer.recv_async(4, 8 + k, got);
        begin
          wr(0, OFF_TXBUF, r[7:0]);
          repeat (6) @(posedge clk);
          rchk(0, OFF_TXCTL, 8'(txm[0]));
        end
      join
      chk(got, (k == 0) ? {7'h00, 1'b1, r[7:0]} : {6'h00, 1'b1, r[8], r[7:0]});
      repeat (4) @(posedge clk);
      rchk(0, OFF_TXCTL, 8'(txm[0]) | 8'h02);
      chk({15'h0000, irq}, (k == 0) ? 16'h0001 : 16'h0000);
      rchk(0, OFF_STAT, 8'h01);
      wr(0, OFF_STAT, 8'h01);
      rchk(0, OFF_STAT, 8'h00);
      chk({15'h0000, irq}, 16'h0000);
    end
    // full duplex on channel b: transmit and receive overlap
    wr(1, OFF_BAUD, 8'h03);
    wr(1, OFF_RCCTL, 8'h90);
    wr(1, OFF_TXCTL, 8'h20);
    r = xs();
    fork
      g_pin[1].i_peer.recv_async(8, 8, got);
      g_pin[1].i_peer.send_async(8, 8, {8'h00, r[15:8]});
      wr(1, OFF_TXBUF, r[7:0]);
    join
    chk(got, {7'h00, 1'b1, r[7:0]});
    repeat (8) @(posedge clk);
    rchk(1, OFF_RXBUF, r[15:8]);
    rchk(1, OFF_STAT, 8'h03);
    rchk(0, OFF_STAT, 8'h00);
    // sync master then slave on channel a
    for (int m = 1; m >= 0; m--) begin
      r = xs();
      wr(0, OFF_TXCTL, (m == 1) ? 8'hB0 : 8'h30);
      fork
        g_pin[0].i_peer.sync_recv(m[0], v);
        wr(0, OFF_TXBUF, r[7:0]);
      join
      chk({8'h00, v}, {8'h00, r[7:0]});
      repeat (8) @(posedge clk);
    end
    // sync master single receive: one word in, then the single enable clears itself
    g_pin[0].i_peer.hold_data(r[16]);
    wr(0, OFF_TXCTL, 8'h90);
    wr(0, OFF_RCCTL, 8'hA0);
    repeat (60) @(posedge clk);
    rchk(0, OFF_RCCTL, 8'h80);
    rchk(0, OFF_RXBUF, {8{r[16]}});
    close_out();
  end

  // the sequence needs well under a thousand cycles; this span of 10000 cycles is ample
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule // usm_top_tb
